// ==== hw/uhtf_pkg.sv ====
/*
 * Package for the host token and frame number register slice.
 * Assumes a single 25 MHz clock and a simple strobed register port.
 */
package uhtf_pkg;

  // ****************************************************************
  // Register map (word index; byte address is index times four)
  // ****************************************************************
  localparam logic [7:0] IDX_DEV_ADDR = 8'h00;
  localparam logic [7:0] IDX_FRM_LOW = 8'h01;
  localparam logic [7:0] IDX_FRM_HIGH = 8'h02;
  localparam logic [7:0] IDX_TOKEN = 8'h03;
  localparam logic [7:0] IDX_CTRL = 8'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOW_SPEED_BIT = 7;
  localparam int FRM_HIGH_W = 3;
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;

  // ****************************************************************
  // Reset values and transaction codes
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [10:0] RST_FRAME = 11'h000;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;

  // Token handed to the transaction engine
  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endpoint_select;
    logic [6:0] bus_device_number;
    logic low_speed_select;
  } uhtf_token_s;

  // Software register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhtf_req_s;

endpackage : uhtf_pkg

// ==== hw/uhtf_regs.sv ====
/*
 * Register slice: device address, frame number capture and host token.
 * Assumes software accesses are synchronous single-cycle strobes and the
 * receive path pulses sof_seen with the frame count of the received SOF.
 */
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module uhtf_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Receive path
  input wire logic sof_seen,
  input wire logic [10:0] sof_frame,
  // Transaction engine
  input wire logic xact_done,
  output logic token_start,
  output uhtf_pkg::uhtf_token_s token_out,
  output logic token_in_progress
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] dev_addr;
    logic [10:0] frame;
    logic [7:0] token;
    logic host_mode;
    logic [31:0] rdata;
    uhtf_pkg::uhtf_token_s tok_out;
  } uhtf_state_s;

  uhtf_state_s state_r;
  uhtf_state_s state_nxt;
  logic start_w;
  logic busy_w;
  logic start_d_r;
  logic token_write;

  // Address match helper, used by the write decoder and the token-write strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction : hit

  assign token_write = reg_wr && hit(reg_addr, uhtf_pkg::IDX_TOKEN);

  // ****************************************************************
  // Token controller
  // ****************************************************************
  uhtf_token_ctl u_tok (
    .clk(clk),
    .reset_n(reset_n),
    .host_mode(state_r.host_mode),
    .token_write(token_write && !busy_w),
    .xact_done(xact_done),
    .token_start(start_w),
    .token_in_progress(busy_w)
  );

  // Next-state: writes, SOF capture, read mux
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rdata = 32'h0000_0000;
    if (reg_wr)
    begin
      if (hit(reg_addr, uhtf_pkg::IDX_DEV_ADDR))
      begin
        state_nxt.dev_addr = reg_wdata[7:0];
      end
      if (hit(reg_addr, uhtf_pkg::IDX_FRM_LOW))
      begin
        state_nxt.frame[7:0] = reg_wdata[7:0];
      end
      if (hit(reg_addr, uhtf_pkg::IDX_FRM_HIGH))
      begin
        state_nxt.frame[10:8] = reg_wdata[uhtf_pkg::FRM_HIGH_W-1:0];
      end
      // Token held only while idle so token readback stays truthful
      if (token_write && !busy_w)
      begin
        state_nxt.token = reg_wdata[7:0];
      end
      if (hit(reg_addr, uhtf_pkg::IDX_CTRL))
      begin
        state_nxt.host_mode = reg_wdata[uhtf_pkg::CTRL_HOST_BIT];
      end
    end
    // Hardware capture wins over a same-cycle software write
    if (sof_seen)
    begin
      state_nxt.frame = sof_frame;
    end
    // Latch address and speed for the token being started
    if (start_w)
    begin
      state_nxt.tok_out.pid = state_r.token[7:4];
      state_nxt.tok_out.endpoint_select = state_r.token[3:0];
      state_nxt.tok_out.bus_device_number = state_r.dev_addr[6:0];
      state_nxt.tok_out.low_speed_select =
        state_r.dev_addr[uhtf_pkg::LOW_SPEED_BIT];
    end
    if (reg_rd)
    begin
      case (reg_addr)
        uhtf_pkg::IDX_DEV_ADDR:
        begin
          state_nxt.rdata = {24'h00_0000, state_r.dev_addr};
        end
        uhtf_pkg::IDX_FRM_LOW:
        begin
          state_nxt.rdata = {24'h00_0000, state_r.frame[7:0]};
        end
        uhtf_pkg::IDX_FRM_HIGH:
        begin
          state_nxt.rdata = {29'h0, state_r.frame[10:8]};
        end
        uhtf_pkg::IDX_TOKEN:
        begin
          state_nxt.rdata = {24'h00_0000, state_r.token};
        end
        uhtf_pkg::IDX_CTRL:
        begin
          state_nxt.rdata = {30'h0, busy_w, state_r.host_mode};
        end
        default:
        begin
          state_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register, all fields cleared by reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= '0;
      start_d_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      start_d_r <= start_w;
    end
  end

  // Outputs from flops; start delayed so token_out is already valid
  assign reg_rdata = state_r.rdata;
  assign token_out = state_r.tok_out;
  assign token_start = start_d_r;
  assign token_in_progress = busy_w;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sof_capture: assert property (@(posedge clk) disable iff (!reset_n)
    sof_seen |=> (state_r.frame == $past(sof_frame)))
    else $error("frame not captured on SOF");

  a_frm_high_rd: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == uhtf_pkg::IDX_FRM_HIGH)
      |=> (reg_rdata[31:3] == 29'h0000_0000))
    else $error("frame high upper bits nonzero");

  a_frm_low_rd: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == uhtf_pkg::IDX_FRM_LOW)
      |=> (reg_rdata == {24'h00_0000, $past(state_r.frame[7:0])}))
    else $error("frame low readback wrong");

  a_addr_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && (reg_addr == uhtf_pkg::IDX_DEV_ADDR ||
      reg_addr == uhtf_pkg::IDX_TOKEN)) |=> (reg_rdata[31:8] == 24'h00_0000))
    else $error("upper bits nonzero");

  a_addr_write_rd: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == uhtf_pkg::IDX_DEV_ADDR)
      ##1 (reg_rd && reg_addr == uhtf_pkg::IDX_DEV_ADDR)
      |=> (reg_rdata[7:0] == $past(reg_wdata[7:0], 2)))
    else $error("device address readback wrong");

  a_token_speed: assert property (@(posedge clk) disable iff (!reset_n)
    start_w |=> (token_out.low_speed_select ==
      $past(state_r.dev_addr[uhtf_pkg::LOW_SPEED_BIT])))
    else $error("token speed wrong");

  a_token_pid: assert property (@(posedge clk) disable iff (!reset_n)
    start_w |=> (token_out.pid == $past(state_r.token[7:4]))
      && token_start && token_in_progress)
    else $error("token pid or start wrong");

  a_start_on_write: assert property (@(posedge clk) disable iff (!reset_n)
    (token_write && !busy_w && state_r.host_mode) |-> ##2 token_start)
    else $error("token write did not start");

  a_reset_zero: assert property (@(posedge clk)
    !reset_n |=> (state_r.dev_addr == 8'h00 && state_r.token == 8'h00))
    else $error("registers not zero after reset");

endmodule : uhtf_regs

// ==== hw/uhtf_token_ctl.sv ====
/*
 * Token issue controller: holds busy from a host-mode token write until the
 * transaction engine reports completion or host mode is cleared.
 * Assumes the engine pulses done for one cycle per started token.
 */
`timescale 1ns/100ps
module uhtf_token_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic host_mode,
  input wire logic token_write,
  input wire logic xact_done,
  // Status
  output logic token_start,
  output logic token_in_progress
);

  typedef enum logic {ST_IDLE, ST_BUSY} uhtf_tstate_e;

  typedef struct packed {
    uhtf_tstate_e st;
    logic start;
  } uhtf_tctl_s;

  uhtf_tctl_s state_r;
  uhtf_tctl_s state_nxt;

  // Start only from idle in host mode; a write while busy is dropped
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.start = 1'b0;
    case (state_r.st)
      ST_IDLE:
      begin
        if (token_write && host_mode)
        begin
          state_nxt.st = ST_BUSY;
          state_nxt.start = 1'b1;
        end
      end
      ST_BUSY:
      begin
        // Leaving host mode aborts, since host logic is reset then
        if (xact_done || !host_mode)
        begin
          state_nxt.st = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt.st = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= '{st: ST_IDLE, start: 1'b0};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign token_start = state_r.start;
  assign token_in_progress = (state_r.st == ST_BUSY);

  // A start only ever follows a host-mode write, and busy stands with it
  a_busy_after_start: assert property (@(posedge clk) disable iff (!reset_n)
    token_start |-> token_in_progress && $past(token_write && host_mode))
    else $error("start without host write or busy");

endmodule : uhtf_token_ctl

// ==== test/testbench.sv ====
/*
 * Self-checking bench for the token and frame register slice.
 * Assumes the engine model answers tokens; bench plays software and SOF.
 */
`timescale 1ns/100ps
module testbench;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic sof_seen = 1'b0;
  logic [10:0] sof_frame = 11'h000;
  logic xact_done;
  logic token_start;
  logic token_in_progress;
  logic [3:0] delay = 4'h3;
  uhtf_pkg::uhtf_token_s token_out;
  int fails = 0;
  int checks = 0;
  int starts = 0;
  int n;
  int base;
  always #20 clk = ~clk;
  uhtf_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sof_seen(sof_seen), .sof_frame(sof_frame),
    .xact_done(xact_done), .token_start(token_start),
    .token_out(token_out), .token_in_progress(token_in_progress));
  uhtf_engine_model i_eng (.clk(clk), .reset_n(reset_n),
    .token_start(token_start), .delay(delay), .xact_done(xact_done));
  // Count starts so refused writes show up as missing pulses
  always @(posedge clk)
    if (token_start === 1'b1)
      starts <= starts + 1;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  // Write then read back with no gap between the strobes
  task wr_rd(input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : wr_rd
  // Wait bounded for busy to drop; software polls it first
  task idle;
    n = 0;
    while (token_in_progress !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, token_in_progress}, 32'h0);
  endtask : idle
  task tok(input logic [3:0] p, input logic [3:0] ep, input logic [7:0] ad);
    idle();
    wr(uhtf_pkg::IDX_TOKEN, {24'h0, p, ep});
    #1;
    chk({31'h0, token_in_progress}, 32'h1);
    n = 0;
    while (token_start !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, token_start}, 32'h1);
    chk({16'h0, token_out}, {16'h0, p, ep, ad[6:0], ad[7]});
    idle();
  endtask : tok
  task sof(input logic [10:0] f);
    @(posedge clk);
    sof_seen <= 1'b1;
    sof_frame <= f;
    @(posedge clk);
    sof_seen <= 1'b0;
    rd(uhtf_pkg::IDX_FRM_LOW, {24'h0, f[7:0]});
    rd(uhtf_pkg::IDX_FRM_HIGH, {29'h0, f[10:8]});
  endtask : sof
  task end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(i[7:0], 32'h0);
    wr_rd(uhtf_pkg::IDX_DEV_ADDR, 32'hFFFFFFAB, 32'hAB);
    wr(uhtf_pkg::IDX_FRM_LOW, 32'hFFFFFF5A);
    rd(uhtf_pkg::IDX_FRM_LOW, 32'h5A);
    wr(uhtf_pkg::IDX_FRM_HIGH, 32'hFFFFFFFF);
    rd(uhtf_pkg::IDX_FRM_HIGH, 32'h7);
    sof(11'h7A5);
    // SOF and a frame write in one cycle: capture must win
    @(posedge clk);
    sof_seen <= 1'b1;
    sof_frame <= 11'h123;
    reg_addr <= uhtf_pkg::IDX_FRM_LOW;
    reg_wdata <= 32'h11;
    reg_wr <= 1'b1;
    @(posedge clk);
    sof_seen <= 1'b0;
    reg_wr <= 1'b0;
    rd(uhtf_pkg::IDX_FRM_LOW, 32'h23);
    wr(uhtf_pkg::IDX_CTRL, 32'h1);
    wr(uhtf_pkg::IDX_DEV_ADDR, 32'h85);
    tok(uhtf_pkg::PID_OUT, 4'h0, 8'h85);
    tok(uhtf_pkg::PID_IN, 4'hF, 8'h85);
    delay <= 4'h0;
    wr(uhtf_pkg::IDX_DEV_ADDR, 32'h12);
    tok(uhtf_pkg::PID_SETUP, 4'h5, 8'h12);
    // Second token while busy is dropped, first one holds
    delay <= 4'hA;
    base = starts;
    wr(uhtf_pkg::IDX_TOKEN, 32'h93);
    wr(uhtf_pkg::IDX_TOKEN, 32'h1A);
    rd(uhtf_pkg::IDX_CTRL, 32'h3);
    idle();
    chk(starts - base, 32'h1);
    rd(uhtf_pkg::IDX_TOKEN, 32'h93);
    // Leaving host mode while busy drops busy at once
    wr(uhtf_pkg::IDX_TOKEN, 32'h93);
    wr(uhtf_pkg::IDX_CTRL, 32'h0);
    rd(uhtf_pkg::IDX_CTRL, 32'h0);
    // Host mode off: token write is stored but never started
    base = starts;
    wr(uhtf_pkg::IDX_TOKEN, 32'hD2);
    repeat (4) @(posedge clk);
    chk(starts - base, 32'h0);
    rd(uhtf_pkg::IDX_TOKEN, 32'hD2);
    end_sim();
  end
  // Watchdog well past the hundred or so cycles the run needs
  initial
  begin
    #(40 * 5000);
    fails++;
    end_sim();
  end
endmodule : testbench

// ==== test/uhtf_engine_model.sv ====
/*
 * Behavioural transaction engine on the far side of the token port.
 * Assumes one clock; done follows each start after a set delay.
 */
`timescale 1ns/100ps
module uhtf_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Token side
  input wire logic token_start,
  input wire logic [3:0] delay,
  output logic xact_done
);
  logic busy_r;
  logic [3:0] cnt_r;
  // Slow or prompt bus run; done is a single pulse per token
  always_ff @(posedge clk)
  begin
    xact_done <= 1'b0;
    if (!reset_n)
    begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if (token_start)
    begin
      busy_r <= 1'b1;
      cnt_r <= delay;
    end
    else if (busy_r && cnt_r == 4'h0)
    begin
      busy_r <= 1'b0;
      xact_done <= 1'b1;
    end
    else if (busy_r)
    begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : uhtf_engine_model
